/* amc_pkg.sv */
// Constants, types and states for the asynchronous 16-bit memory port host
// What this block does
// - Data is stored only while select and write strobe overlap low; host forms writes so.
// - Host keeps write strobe high throughout every read cycle.
// - After power-up or supply drop, host waits 2 ms with select and write high.
// - Back-to-back reads keep select and output enable low; only the address and lane strobes change.
package amc_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int LANE_W = 8;
    localparam int LANES = 2;
    localparam int SYNC_STAGES = 2;
    localparam int CNT_W = 4;

    // Timing in ns and derived cycle counts
    localparam int CLK_NS = 100;
    localparam int T_WAIT_NS = 2_000_000;
    localparam int T_RD_ACC_NS = 35;
    localparam int T_WR_PULSE_NS = 15;
    localparam int WAIT_CYC = (T_WAIT_NS + CLK_NS - 1) / CLK_NS;
    localparam int RD_ACC_CYC = (T_RD_ACC_NS + CLK_NS - 1) / CLK_NS;
    localparam int WR_PULSE_CYC = (T_WR_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int RD_WAIT_CYC = RD_ACC_CYC + SYNC_STAGES - 1;

    typedef struct packed {
        logic sel_n;
        logic oe_n;
        logic we_n;
        logic high_lane_strobe_n;
        logic low_lane_strobe_n;
        logic [ADDR_W-1:0] addr;
    } amc_pins_t;

    typedef struct packed {
        logic write;
        logic [LANES-1:0] lanes;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } amc_req_t;

    typedef enum logic [2:0] {
        AMC_WAIT,
        AMC_IDLE,
        AMC_RD,
        AMC_WR_SETUP,
        AMC_WR_PULSE,
        AMC_WR_HOLD
    } amc_state_t;

    // Reset and idle values of the pins
    localparam amc_pins_t PINS_RST = '{sel_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
        high_lane_strobe_n: 1'b1, low_lane_strobe_n: 1'b1, addr: 16'h0000};
    localparam logic [LANES-1:0] LANE_OE_RST = 2'h3;
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
endpackage

/* amc_wait_timer.sv */
// Power-up wait timer, restarted by a supply drop
`timescale 1ns/1ps
module amc_wait_timer #(
    parameter int WAIT_CYC = amc_pkg::WAIT_CYC
) (
    // Clock, reset, enable
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic en,
    // Control
    input wire logic restart,
    output logic done
);
    import amc_pkg::*;

    localparam int TW = $clog2(WAIT_CYC + 1);
    localparam logic [TW-1:0] LAST = TW'(WAIT_CYC - 1);

    logic [TW-1:0] cnt_r;
    logic [TW-1:0] cnt_nxt;
    logic done_r;
    logic done_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        done_nxt = done_r;
        if (restart) begin
            cnt_nxt = '0;
            done_nxt = 1'b0;
        end else if (!done_r) begin
            if (cnt_r == LAST) begin
                done_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + TW'(1);
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_r <= '0;
            done_r <= 1'b0;
        end else if (en) begin
            cnt_r <= cnt_nxt;
            done_r <= done_nxt;
        end
    end

    assign done = done_r;
endmodule

/* amc_mem_host.sv */
// Host controller driving the asynchronous 16-bit memory port pins
`timescale 1ns/1ps
module amc_mem_host #(
    parameter int WAIT_CYC = amc_pkg::WAIT_CYC
) (
    // Clock, reset, enable
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic en,
    // Request side
    input wire amc_pkg::amc_req_t req,
    input wire logic req_valid,
    output logic req_ready,
    // Response side
    output logic [amc_pkg::DATA_W-1:0] rsp_data,
    output logic rsp_valid,
    // Supply monitor and status
    input wire logic supply_low,
    output logic mem_usable,
    // Memory strobes and address
    output amc_pkg::amc_pins_t mem_pins,
    // Data lanes, three signals each
    input wire logic [amc_pkg::LANE_W-1:0] low_data_lane_rd,
    input wire logic [amc_pkg::LANE_W-1:0] high_data_lane_rd,
    output logic [amc_pkg::LANE_W-1:0] low_data_lane_wr,
    output logic [amc_pkg::LANE_W-1:0] high_data_lane_wr,
    output logic low_data_lane_oe_n,
    output logic high_data_lane_oe_n
);
    import amc_pkg::*;

    localparam int SW = DATA_W + 1;
    localparam logic [CNT_W-1:0] RD_LAST = CNT_W'(RD_WAIT_CYC);
    localparam logic [CNT_W-1:0] RD_PRE = CNT_W'(RD_WAIT_CYC - 1);
    localparam logic [CNT_W-1:0] WR_LAST = CNT_W'(WR_PULSE_CYC - 1);

    // Pin input synchronisers
    logic [SW-1:0] sync1_r;
    logic [SW-1:0] sync1_nxt;
    logic [SW-1:0] sync2_r;
    logic [SW-1:0] sync2_nxt;
    logic low_s;
    logic [DATA_W-1:0] rd_s;

    always_comb begin
        sync1_nxt = {supply_low, high_data_lane_rd, low_data_lane_rd};
        sync2_nxt = sync1_r;
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else if (en) begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
        end
    end

    assign low_s = sync2_r[SW-1];
    assign rd_s = sync2_r[DATA_W-1:0];

    // Power-up wait
    logic wait_done;

    amc_wait_timer #(
        .WAIT_CYC(WAIT_CYC)
    ) u_wait (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .en(en),
        .restart(low_s),
        .done(wait_done)
    );

    // Access sequencer
    amc_state_t state_r;
    amc_state_t state_nxt;
    amc_pins_t pins_r;
    amc_pins_t pins_nxt;
    amc_req_t cur_r;
    amc_req_t cur_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic ready_r;
    logic ready_nxt;
    logic rsp_valid_r;
    logic rsp_valid_nxt;
    logic [DATA_W-1:0] rsp_data_r;
    logic [DATA_W-1:0] rsp_data_nxt;
    logic [DATA_W-1:0] wr_r;
    logic [DATA_W-1:0] wr_nxt;
    logic [LANES-1:0] lane_oe_n_r;
    logic [LANES-1:0] lane_oe_n_nxt;
    logic usable_r;
    logic usable_nxt;
    logic take;

    assign take = req_valid && ready_r;

    always_comb begin
        state_nxt = state_r;
        pins_nxt = pins_r;
        cur_nxt = cur_r;
        cnt_nxt = cnt_r;
        ready_nxt = 1'b0;
        rsp_valid_nxt = 1'b0;
        rsp_data_nxt = rsp_data_r;
        wr_nxt = wr_r;
        lane_oe_n_nxt = lane_oe_n_r;
        usable_nxt = usable_r;
        unique case (state_r)
            AMC_WAIT: begin
                pins_nxt = PINS_RST;
                if (wait_done) begin
                    state_nxt = AMC_IDLE;
                    ready_nxt = 1'b1;
                    usable_nxt = 1'b1;
                end
            end
            AMC_IDLE: begin
                ready_nxt = 1'b1;
                if (take) begin
                    ready_nxt = 1'b0;
                    cur_nxt = req;
                    cnt_nxt = '0;
                    pins_nxt.sel_n = 1'b0;
                    pins_nxt.addr = req.addr;
                    pins_nxt.low_lane_strobe_n = ~req.lanes[0];
                    pins_nxt.high_lane_strobe_n = ~req.lanes[1];
                    // write strobe stays high on reads
                    pins_nxt.we_n = 1'b1;
                    pins_nxt.oe_n = req.write;
                    state_nxt = req.write ? AMC_WR_SETUP : AMC_RD;
                end
            end
            AMC_RD: begin
                cnt_nxt = cnt_r + CNT_W'(1);
                if (cnt_r == RD_PRE) begin
                    ready_nxt = 1'b1;
                end
                if (cnt_r == RD_LAST) begin
                    rsp_valid_nxt = 1'b1;
                    rsp_data_nxt = rd_s;
                    cnt_nxt = '0;
                    if (take && !req.write) begin
                        // only the address and lanes move
                        cur_nxt = req;
                        pins_nxt.addr = req.addr;
                        pins_nxt.low_lane_strobe_n = ~req.lanes[0];
                        pins_nxt.high_lane_strobe_n = ~req.lanes[1];
                    end else if (take) begin
                        // output enable off one cycle before driving
                        cur_nxt = req;
                        pins_nxt.oe_n = 1'b1;
                        pins_nxt.addr = req.addr;
                        pins_nxt.low_lane_strobe_n = ~req.lanes[0];
                        pins_nxt.high_lane_strobe_n = ~req.lanes[1];
                        state_nxt = AMC_WR_SETUP;
                    end else begin
                        pins_nxt = PINS_RST;
                        pins_nxt.addr = pins_r.addr;
                        ready_nxt = 1'b1;
                        state_nxt = AMC_IDLE;
                    end
                end
            end
            AMC_WR_SETUP: begin
                // write strobe low inside select, data driven
                pins_nxt.we_n = 1'b0;
                wr_nxt = cur_r.wdata;
                lane_oe_n_nxt = ~cur_r.lanes;
                cnt_nxt = '0;
                state_nxt = AMC_WR_PULSE;
            end
            AMC_WR_PULSE: begin
                cnt_nxt = cnt_r + CNT_W'(1);
                if (cnt_r == WR_LAST) begin
                    pins_nxt.we_n = 1'b1;
                    state_nxt = AMC_WR_HOLD;
                end
            end
            AMC_WR_HOLD: begin
                lane_oe_n_nxt = LANE_OE_RST;
                pins_nxt = PINS_RST;
                pins_nxt.addr = pins_r.addr;
                ready_nxt = 1'b1;
                state_nxt = AMC_IDLE;
            end
        endcase
        if (low_s) begin
            state_nxt = AMC_WAIT;
            pins_nxt = PINS_RST;
            lane_oe_n_nxt = LANE_OE_RST;
            ready_nxt = 1'b0;
            usable_nxt = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= AMC_WAIT;
            pins_r <= PINS_RST;
            cur_r <= '0;
            cnt_r <= '0;
            ready_r <= 1'b0;
            rsp_valid_r <= 1'b0;
            rsp_data_r <= DATA_RST;
            wr_r <= DATA_RST;
            lane_oe_n_r <= LANE_OE_RST;
            usable_r <= 1'b0;
        end else if (en) begin
            state_r <= state_nxt;
            pins_r <= pins_nxt;
            cur_r <= cur_nxt;
            cnt_r <= cnt_nxt;
            ready_r <= ready_nxt;
            rsp_valid_r <= rsp_valid_nxt;
            rsp_data_r <= rsp_data_nxt;
            wr_r <= wr_nxt;
            lane_oe_n_r <= lane_oe_n_nxt;
            usable_r <= usable_nxt;
        end
    end

    assign req_ready = ready_r;
    assign rsp_valid = rsp_valid_r;
    assign rsp_data = rsp_data_r;
    assign mem_usable = usable_r;
    assign mem_pins = pins_r;
    assign low_data_lane_wr = wr_r[LANE_W-1:0];
    assign high_data_lane_wr = wr_r[DATA_W-1:LANE_W];
    assign low_data_lane_oe_n = lane_oe_n_r[0];
    assign high_data_lane_oe_n = lane_oe_n_r[1];

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    a_wait_pins_high: assert property (!usable_r |-> pins_r.sel_n && pins_r.we_n)
        else $error("select or write low during power-up wait");
    a_read_we_high: assert property (!pins_r.oe_n |-> pins_r.we_n)
        else $error("write strobe low while output enabled");
    a_no_contention: assert property ((lane_oe_n_r != LANE_OE_RST) |->
        pins_r.oe_n && $past(pins_r.oe_n))
        else $error("data driven while memory may drive");
    a_write_overlap: assert property (!pins_r.we_n |-> !pins_r.sel_n
        && lane_oe_n_r == {pins_r.high_lane_strobe_n, pins_r.low_lane_strobe_n})
        else $error("write strobe outside select or lanes mismatch");
    a_write_pulse_len: assert property (en && $fell(pins_r.we_n) |-> ##1 pins_r.we_n)
        else $error("write pulse length wrong");
    a_data_hold_end: assert property (en && $rose(pins_r.we_n) && !low_s |->
        lane_oe_n_r == {pins_r.high_lane_strobe_n, pins_r.low_lane_strobe_n})
        else $error("data released before write strobe rise");
    a_burst_read_sel: assert property (en && state_r == AMC_RD && cnt_r == RD_LAST && take
        && !req.write && !low_s |-> ##1 !pins_r.sel_n && !pins_r.oe_n)
        else $error("burst read dropped select or output enable");
    a_read_rsp_time: assert property (en && $fell(pins_r.oe_n) |-> ##[1:3] rsp_valid_r)
        else $error("read data not returned in time");

    c_word_read: cover property (take && !req.write && req.lanes == 2'h3);
    c_byte_write: cover property (take && req.write && req.lanes == 2'h1);
    c_burst_read: cover property (state_r == AMC_RD && cnt_r == RD_LAST && take && !req.write);
    c_supply_drop: cover property (usable_r && low_s);
endmodule

/* amc_mem_model.sv */
// Behavioural model of the asynchronous 16-bit memory device
`timescale 1ns/1ps
module amc_mem_model (
    // Strobes and supply
    input wire amc_pkg::amc_pins_t mem_pins,
    input wire logic supply_low,
    // Host lane drive
    input wire logic [amc_pkg::LANE_W-1:0] low_data_lane_wr,
    input wire logic [amc_pkg::LANE_W-1:0] high_data_lane_wr,
    input wire logic low_data_lane_oe_n,
    input wire logic high_data_lane_oe_n,
    // Wire levels and contention flag
    output logic [amc_pkg::LANE_W-1:0] low_data_lane_rd,
    output logic [amc_pkg::LANE_W-1:0] high_data_lane_rd,
    output logic clash
);
    import amc_pkg::*;
    logic [DATA_W-1:0] mem [0:65535];
    logic [DATA_W-1:0] last_q;
    logic [DATA_W-1:0] dev_q;
    logic rd_mode, drv_lo, drv_hi;
    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = DATA_RST;
        end
        last_q = DATA_RST;
    end
    assign rd_mode = !mem_pins.sel_n && !mem_pins.oe_n && mem_pins.we_n;
    assign drv_lo = rd_mode && !mem_pins.low_lane_strobe_n;
    assign drv_hi = rd_mode && !mem_pins.high_lane_strobe_n;
    always @* begin
        if (drv_lo) last_q[7:0] = mem[mem_pins.addr][7:0];
        if (drv_hi) last_q[15:8] = mem[mem_pins.addr][15:8];
    end
    assign dev_q = {drv_hi ? last_q[15:8] : ~last_q[15:8], drv_lo ? last_q[7:0] : ~last_q[7:0]};
    assign low_data_lane_rd = low_data_lane_oe_n ? dev_q[7:0] : (drv_lo ? 8'hXX : low_data_lane_wr);
    assign high_data_lane_rd = high_data_lane_oe_n ? dev_q[15:8] :
        (drv_hi ? 8'hXX : high_data_lane_wr);
    assign clash = (drv_lo && !low_data_lane_oe_n) || (drv_hi && !high_data_lane_oe_n);
    always @(posedge mem_pins.we_n or posedge mem_pins.sel_n) begin
        if ((!mem_pins.sel_n || !mem_pins.we_n) && !supply_low) begin
            if (!mem_pins.low_lane_strobe_n)
                mem[mem_pins.addr][7:0] = low_data_lane_oe_n ? 8'hXX : low_data_lane_wr;
            if (!mem_pins.high_lane_strobe_n)
                mem[mem_pins.addr][15:8] = high_data_lane_oe_n ? 8'hXX : high_data_lane_wr;
        end
    end
endmodule

/* test_amc_mem_host.sv */
// Self-checking bench for the memory port host with a device model
`timescale 1ns/1ps
module test_amc_mem_host;
    import amc_pkg::*;
    localparam int WAIT_SIM = 20;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic en = 1'b1;
    logic supply_low = 1'b0;
    amc_req_t req = '0;
    logic req_valid = 1'b0;
    logic req_ready, rsp_valid, mem_usable, lo_oe_n, hi_oe_n, clash;
    logic [DATA_W-1:0] rsp_data;
    amc_pins_t mem_pins;
    logic [LANE_W-1:0] lo_rd, hi_rd, lo_wr, hi_wr;
    logic [31:0] x, r;
    int bad_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    int err_rd = 0, err_wait = 0, err_burst = 0, err_clash = 0;
    int ref_mem [int];
    logic [31:0] exp_q [$];
    int cyc_q [$];
    bit burst = 0;
    always #50 ref_clk = ~ref_clk;
    amc_mem_host #(.WAIT_CYC(WAIT_SIM)) u_amc_mem_host (.ref_clk(ref_clk), .resetn(resetn),
        .en(en), .req(req), .req_valid(req_valid), .req_ready(req_ready), .rsp_data(rsp_data),
        .rsp_valid(rsp_valid), .supply_low(supply_low), .mem_usable(mem_usable),
        .mem_pins(mem_pins), .low_data_lane_rd(lo_rd), .high_data_lane_rd(hi_rd),
        .low_data_lane_wr(lo_wr), .high_data_lane_wr(hi_wr), .low_data_lane_oe_n(lo_oe_n),
        .high_data_lane_oe_n(hi_oe_n));
    amc_mem_model u_amc_mem_model (.mem_pins(mem_pins), .supply_low(supply_low),
        .low_data_lane_wr(lo_wr), .high_data_lane_wr(hi_wr), .low_data_lane_oe_n(lo_oe_n),
        .high_data_lane_oe_n(hi_oe_n), .low_data_lane_rd(lo_rd), .high_data_lane_rd(hi_rd),
        .clash(clash));
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(negedge ref_clk) begin
        cycles++;
        if (clash === 1'b1) err_clash++;
        if (mem_pins.oe_n === 1'b0 && mem_pins.we_n !== 1'b1) err_rd++;
        if (resetn && mem_usable === 1'b0 && (mem_pins.sel_n !== 1'b1 || mem_pins.we_n !== 1'b1))
            err_wait++;
        if (burst && (mem_pins.sel_n !== 1'b0 || mem_pins.oe_n !== 1'b0)) err_burst++;
        if (rsp_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("rsp_extra", 1, 0);
            end else begin
                x = exp_q.pop_front();
                check("rsp_data", rsp_data & x[31:16], x[15:0] & x[31:16]);
                check("rsp_latency", cycles - cyc_q.pop_front(), 4);
            end
        end
        if (cycles > 6000) begin
            bad_count++;
            finish_test();
        end
    end
    task automatic issue(logic wr, logic [1:0] ln, logic [15:0] a, logic [15:0] d);
        int n;
        logic [15:0] m, e;
        n = 0;
        m = {{8{ln[1]}}, {8{ln[0]}}};
        req = '{write: wr, lanes: ln, addr: a, wdata: d};
        req_valid = 1'b1;
        @(negedge ref_clk);
        while (req_ready !== 1'b1 && n < 50) begin
            @(negedge ref_clk);
            n++;
        end
        check("ready_seen", n < 50, 1);
        @(posedge ref_clk);
        #1;
        e = ref_mem.exists(a) ? 16'(ref_mem[a]) : 16'h0000;
        if (wr) begin
            ref_mem[a] = (e & ~m) | (d & m);
        end else begin
            exp_q.push_back({m, e});
            cyc_q.push_back(cycles);
        end
    endtask
    task automatic wait_usable();
        int n;
        n = 0;
        while (mem_usable !== 1'b1 && n < 200) begin
            @(negedge ref_clk);
            n++;
        end
        check("wait_min", n >= WAIT_SIM, 1);
        check("wait_max", n <= WAIT_SIM + 4, 1);
        @(posedge ref_clk);
        #1;
    endtask
    task automatic drain();
        int n;
        n = 0;
        while (exp_q.size() != 0 && n < 20) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        check("drained", exp_q.size(), 0);
    endtask
    initial begin
        void'($urandom(5301));
        repeat (10) @(posedge ref_clk);
        #1 resetn = 1'b1;
        wait_usable();
        $display("test power_up_wait done");
        for (int i = 0; i < 4; i++) issue(1'b1, 2'h3, 16'h0040 + 16'(i), 16'($urandom));
        for (int i = 0; i < 4; i++) begin
            issue(1'b0, 2'h3, 16'h0040 + 16'(i), 16'h0000);
            burst = (i < 3);
        end
        $display("test read_burst done");
        for (int i = 0; i < 40; i++) begin
            r = $urandom;
            issue(r[4], r[6:5], {12'h000, r[3:0]}, r[31:16]);
        end
        req_valid = 1'b0;
        drain();
        $display("test random_mix done");
        issue(1'b1, 2'h3, 16'h1000, 16'h5A5A);
        req_valid = 1'b0;
        supply_low = 1'b1;
        repeat (5) @(posedge ref_clk);
        #1;
        check("usable_low", mem_usable, 0);
        check("ready_low", req_ready, 0);
        supply_low = 1'b0;
        wait_usable();
        issue(1'b0, 2'h3, 16'h0041, 16'h0000);
        req_valid = 1'b0;
        drain();
        $display("test supply_drop done");
        en = 1'b0;
        req = '{write: 1'b0, lanes: 2'h3, addr: 16'h0041, wdata: 16'h0000};
        req_valid = 1'b1;
        repeat (5) @(posedge ref_clk);
        #1;
        check("frozen_select", mem_pins.sel_n, 1);
        check("frozen_ready", req_ready, 1);
        req_valid = 1'b0;
        en = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1;
        check("enable_no_access", mem_pins.sel_n, 1);
        $display("test clock_enable done");
        check("write_strobe_in_read", err_rd, 0);
        check("strobes_in_wait", err_wait, 0);
        check("burst_pins", err_burst, 0);
        check("lane_contention", err_clash, 0);
        finish_test();
    end
endmodule
